// ---- cftu_pkg.sv ----
// How it works
// RQ1 - Five-bit condition field gives twenty codes; code 00000 always passes.
// RQ2 - Every conditional instruction may select the always-true code.
// RQ3 - Non-compare results touch flags only when writing extended registers R0 to R7.
// RQ4 - Float, integer compares and bit tests, both forms, always update flags.
// RQ5 - Float result: 8-bit exponent, sign, 31-bit fraction; integer and logical 32-bit.
// RQ6 - Sign: output MSB for logical; negative result for integer and float.
// RQ7 - Zero flag set when the output is zero, else cleared.
// RQ8 - Integer overflow when result does not fit signed 32 bits.
// RQ9 - Float overflow when exponent exceeds 127; logical ops clear overflow.
// RQ10 - Carry on add carry-out or subtract borrow; other integer ops clear it.
// RQ11 - Float and logical ops leave carry unchanged.
// RQ12 - Float exponent at or below -128 sets underflow and zeroes output.
// RQ13 - Sticky overflow follows overflow sets; cleared by reset or flag word write.
// RQ14 - Sticky underflow follows underflow sets; cleared by reset or flag word write.
// RQ15 - Unsigned codes 00001 to 00110 test carry and zero.
// RQ16 - Signed codes 00111 to 01010 test sign and zero.
// RQ17 - Compare-to-zero codes reuse the signed and equality codes.
// RQ18 - Direct overflow, underflow and sticky tests in true and complemented sense.
// RQ19 - Condition pass is combinational over current flags, same cycle.
package cftu_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [4:0] ADDR_FLAG_WORD = 5'h00;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h04;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h08;
	localparam logic [4:0] ADDR_COND_SEL = 5'h0c;

	// ----------------------------------------
	// Flag word layout
	// ----------------------------------------
	localparam int FLAG_W = 7;
	localparam int FB_CARRY = 0;
	localparam int FB_OVF = 1;
	localparam int FB_ZERO = 2;
	localparam int FB_SIGN = 3;
	localparam int FB_UF = 4;
	localparam int FB_LV = 5;
	localparam int FB_LUF = 6;
	localparam logic [6:0] FLAG_RST = 7'h00;

	// Interrupt status bits and the condition pass bit of the select readback
	localparam int IRQ_W = 2;
	localparam int IB_OVF = 0;
	localparam int IB_UF = 1;
	localparam int COND_PASS_BIT = 8;

	// ----------------------------------------
	// Result formats
	// ----------------------------------------
	localparam int INT_W = 32;
	localparam int FRAC_W = 31;
	localparam int EXPO_W = 8;
	localparam int RES_W = EXPO_W + 1 + FRAC_W;
	localparam int FLT_EXP_MAX = 127;
	localparam int FLT_EXP_MIN = -128;
	localparam logic [7:0] FLT_ZERO_EXP = 8'h80;

	// Operation classes and integer kinds
	localparam logic [1:0] CLS_LOGIC = 2'h0;
	localparam logic [1:0] CLS_INT = 2'h1;
	localparam logic [1:0] CLS_FLOAT = 2'h2;
	localparam logic [1:0] IOP_ADD = 2'h0;
	localparam logic [1:0] IOP_SUB = 2'h1;
	localparam logic [1:0] IOP_OTHER = 2'h2;

	// ----------------------------------------
	// Condition codes
	// ----------------------------------------
	localparam logic [4:0] CC_ALWAYS = 5'h00;
	localparam logic [4:0] CC_UNSIGNED_LESS = 5'h01;
	localparam logic [4:0] CC_UNSIGNED_NOT_ABOVE = 5'h02;
	localparam logic [4:0] CC_UNSIGNED_ABOVE = 5'h03;
	localparam logic [4:0] CC_UNSIGNED_AT_LEAST = 5'h04;
	localparam logic [4:0] CC_SAME_VALUE = 5'h05;
	localparam logic [4:0] CC_DIFFER = 5'h06;
	localparam logic [4:0] CC_SIGNED_BELOW = 5'h07;
	localparam logic [4:0] CC_SIGNED_AT_MOST = 5'h08;
	localparam logic [4:0] CC_SIGNED_ABOVE = 5'h09;
	localparam logic [4:0] CC_SIGNED_AT_LEAST = 5'h0a;
	localparam logic [4:0] CC_NO_OVF = 5'h0b;
	localparam logic [4:0] CC_OVF = 5'h0c;
	localparam logic [4:0] CC_NO_UF = 5'h0d;
	localparam logic [4:0] CC_UF = 5'h0e;
	localparam logic [4:0] CC_NO_LV = 5'h0f;
	localparam logic [4:0] CC_LV = 5'h10;
	localparam logic [4:0] CC_NO_LUF = 5'h11;
	localparam logic [4:0] CC_LUF = 5'h12;
	localparam logic [4:0] CC_ZERO_OR_UF = 5'h13;

endpackage : cftu_pkg

// ---- cftu_flag_unit.sv ----
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cftu_flag_unit #(
	parameter int EXP_W = 10
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Result from the execution datapath
	input wire logic res_valid_i,
	input wire logic [1:0] op_class_i,
	input wire logic [1:0] int_op_i,
	input wire logic cmp_op_i,
	input wire logic dst_ext_i,
	input wire logic [31:0] op_a_i,
	input wire logic [31:0] op_b_i,
	input wire logic [31:0] word_res_i,
	input wire logic int_ovf_i,
	input wire logic [EXP_W-1:0] flt_exp_i,
	input wire logic flt_sign_i,
	input wire logic [30:0] flt_frac_i,
	input wire logic flt_zero_i,
	// Condition test for the sequencer
	input wire logic [4:0] cond_i,
	output logic cond_pass_o,
	// Flag word and written-back output
	output logic [6:0] cpu_flag_word_o,
	output logic [39:0] result_o,
	output logic result_valid_o,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (EXP_W < 9 || EXP_W > 16) begin : g_bad_exp
		$error("EXP_W must lie between 9 and 16");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [6:0] flags;
		logic [39:0] result;
		logic res_valid;
		logic wait_n;
		logic [31:0] rdata;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic irq;
		logic [4:0] cond_sel;
	} cftu_state_t;

	cftu_state_t st_reg;
	cftu_state_t st_next;

	// Condition test over a flag word
	function automatic logic cftu_eval(input logic [4:0] sel, input logic [6:0] f);
		logic c;
		logic v;
		logic z;
		logic n;
		logic r;
		c = f[cftu_pkg::FB_CARRY];
		v = f[cftu_pkg::FB_OVF];
		z = f[cftu_pkg::FB_ZERO];
		n = f[cftu_pkg::FB_SIGN];
		case (sel)
			cftu_pkg::CC_ALWAYS: r = 1'b1; // RQ1 RQ2
			cftu_pkg::CC_UNSIGNED_LESS: r = c; // RQ15
			cftu_pkg::CC_UNSIGNED_NOT_ABOVE: r = c | z; // RQ15
			cftu_pkg::CC_UNSIGNED_ABOVE: r = ~c & ~z; // RQ15
			cftu_pkg::CC_UNSIGNED_AT_LEAST: r = ~c; // RQ15
			cftu_pkg::CC_SAME_VALUE: r = z; // RQ15 RQ17
			cftu_pkg::CC_DIFFER: r = ~z; // RQ15 RQ17
			cftu_pkg::CC_SIGNED_BELOW: r = n; // RQ16 RQ17
			cftu_pkg::CC_SIGNED_AT_MOST: r = n | z; // RQ16
			cftu_pkg::CC_SIGNED_ABOVE: r = ~n & ~z; // RQ16 RQ17
			cftu_pkg::CC_SIGNED_AT_LEAST: r = ~n; // RQ16 RQ17
			cftu_pkg::CC_NO_OVF: r = ~v; // RQ18
			cftu_pkg::CC_OVF: r = v; // RQ18
			cftu_pkg::CC_NO_UF: r = ~f[cftu_pkg::FB_UF]; // RQ18
			cftu_pkg::CC_UF: r = f[cftu_pkg::FB_UF]; // RQ18
			cftu_pkg::CC_NO_LV: r = ~f[cftu_pkg::FB_LV]; // RQ18
			cftu_pkg::CC_LV: r = f[cftu_pkg::FB_LV]; // RQ18
			cftu_pkg::CC_NO_LUF: r = ~f[cftu_pkg::FB_LUF]; // RQ18
			cftu_pkg::CC_LUF: r = f[cftu_pkg::FB_LUF]; // RQ18
			cftu_pkg::CC_ZERO_OR_UF: r = z | f[cftu_pkg::FB_UF]; // RQ18
			default: r = 1'b0; // Codes past the twenty defined never pass
		endcase
		return r;
	endfunction : cftu_eval

	// ----------------------------------------
	// Result evaluation
	// ----------------------------------------
	logic upd;
	logic [32:0] add_w;
	logic [32:0] sub_w;
	logic [31:0] int_res;
	logic int_v;
	logic int_c;
	logic flt_ovf;
	logic flt_uf;
	logic [6:0] hw_flags;
	logic [39:0] out_val;
	logic bus_req;
	logic bus_take;
	logic fw_write;
	logic [1:0] irq_ev;

	// Only extended-register writes or compares move the flags
	assign upd = res_valid_i & (cmp_op_i | dst_ext_i); // RQ3 RQ4
	assign add_w = {1'b0, op_a_i} + {1'b0, op_b_i};
	assign sub_w = {1'b0, op_a_i} - {1'b0, op_b_i};

	// Integer result, carry and overflow from the operands for add and subtract
	always_comb begin
		int_res = word_res_i;
		int_c = 1'b0; // RQ10
		int_v = int_ovf_i; // RQ8
		case (int_op_i)
			cftu_pkg::IOP_ADD: begin
				int_res = add_w[31:0];
				int_c = add_w[32]; // RQ10
				int_v = (op_a_i[31] == op_b_i[31]) && (add_w[31] != op_a_i[31]); // RQ8
			end
			cftu_pkg::IOP_SUB: begin
				int_res = sub_w[31:0];
				int_c = sub_w[32]; // RQ10
				int_v = (op_a_i[31] != op_b_i[31]) && (sub_w[31] != op_a_i[31]); // RQ8
			end
			default: begin
				int_res = word_res_i;
			end
		endcase
	end

	// Exponent is carried wider than 8 bits so out-of-range results are seen
	assign flt_ovf = !flt_zero_i && ($signed(flt_exp_i) > cftu_pkg::FLT_EXP_MAX); // RQ9
	assign flt_uf = !flt_zero_i && ($signed(flt_exp_i) <= cftu_pkg::FLT_EXP_MIN); // RQ12

	// New flag word and output value for one result
	always_comb begin
		hw_flags = st_reg.flags;
		out_val = {8'h00, word_res_i};
		case (op_class_i)
			cftu_pkg::CLS_LOGIC: begin
				out_val = {8'h00, word_res_i}; // RQ5
				hw_flags[cftu_pkg::FB_SIGN] = word_res_i[31]; // RQ6
				hw_flags[cftu_pkg::FB_ZERO] = (word_res_i == 32'h0000_0000); // RQ7
				hw_flags[cftu_pkg::FB_OVF] = 1'b0; // RQ9
				hw_flags[cftu_pkg::FB_UF] = 1'b0;
			end
			cftu_pkg::CLS_INT: begin
				out_val = {8'h00, int_res}; // RQ5
				hw_flags[cftu_pkg::FB_SIGN] = int_res[31]; // RQ6
				hw_flags[cftu_pkg::FB_ZERO] = (int_res == 32'h0000_0000); // RQ7
				hw_flags[cftu_pkg::FB_OVF] = int_v; // RQ8
				hw_flags[cftu_pkg::FB_CARRY] = int_c; // RQ10
				hw_flags[cftu_pkg::FB_UF] = 1'b0;
			end
			default: begin
				// Float layout: exponent, sign, fraction
				out_val = {flt_exp_i[7:0], flt_sign_i, flt_frac_i}; // RQ5
				if (flt_uf || flt_zero_i) begin
					out_val = {cftu_pkg::FLT_ZERO_EXP, 1'b0, 31'h0000_0000}; // RQ12
				end
				hw_flags[cftu_pkg::FB_SIGN] = flt_sign_i & ~flt_zero_i & ~flt_uf; // RQ6
				hw_flags[cftu_pkg::FB_ZERO] = flt_zero_i | flt_uf; // RQ7
				hw_flags[cftu_pkg::FB_OVF] = flt_ovf; // RQ9
				hw_flags[cftu_pkg::FB_UF] = flt_uf; // RQ12
			end
		endcase
		// Sticky flags only ever gain here
		hw_flags[cftu_pkg::FB_LV] = st_reg.flags[cftu_pkg::FB_LV] | hw_flags[cftu_pkg::FB_OVF]; // RQ13
		hw_flags[cftu_pkg::FB_LUF] = st_reg.flags[cftu_pkg::FB_LUF] | hw_flags[cftu_pkg::FB_UF]; // RQ14
	end

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// One wait cycle per access keeps decode off the answer path
	assign bus_req = avs_read_i | avs_write_i;
	assign bus_take = bus_req & ~st_reg.wait_n;
	assign fw_write = bus_take & avs_write_i & (avs_address_i == cftu_pkg::ADDR_FLAG_WORD);
	assign irq_ev = upd ? {hw_flags[cftu_pkg::FB_UF], hw_flags[cftu_pkg::FB_OVF]} : 2'b00;

	// Pass is combinational so a conditional op is gated in its own cycle
	assign cond_pass_o = cftu_eval(cond_i, st_reg.flags); // RQ19

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.res_valid = res_valid_i;
		if (res_valid_i) begin
			st_next.result = out_val;
		end
		// Software write first, then a same-cycle result lands on top of it
		if (fw_write) begin
			st_next.flags = avs_writedata_i[6:0]; // RQ13 RQ14
		end
		if (upd) begin
			st_next.flags = hw_flags; // RQ3 RQ4 RQ11
			if (fw_write) begin
				st_next.flags[cftu_pkg::FB_LV] = avs_writedata_i[cftu_pkg::FB_LV] | hw_flags[cftu_pkg::FB_OVF];
				st_next.flags[cftu_pkg::FB_LUF] = avs_writedata_i[cftu_pkg::FB_LUF] | hw_flags[cftu_pkg::FB_UF];
				if (op_class_i != cftu_pkg::CLS_INT) begin
					st_next.flags[cftu_pkg::FB_CARRY] = avs_writedata_i[cftu_pkg::FB_CARRY]; // RQ11
				end
			end
		end
		// Request is answered one cycle after it appears
		st_next.wait_n = bus_req & st_reg.wait_n ? 1'b0 : 1'b1;
		if (bus_req && st_reg.wait_n) begin
			st_next.rdata = 32'h0000_0000;
			case (avs_address_i)
				cftu_pkg::ADDR_FLAG_WORD: st_next.rdata = {25'h000_0000, st_reg.flags};
				cftu_pkg::ADDR_IRQ_STAT: st_next.rdata = {30'h0000_0000, st_reg.irq_stat};
				cftu_pkg::ADDR_IRQ_MASK: st_next.rdata = {30'h0000_0000, st_reg.irq_mask};
				cftu_pkg::ADDR_COND_SEL: begin
					st_next.rdata = {23'h00_0000, cftu_eval(st_reg.cond_sel, st_reg.flags), 3'h0, st_reg.cond_sel};
				end
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
		// Interrupt status: write one clears, a new event wins over the clear
		if (bus_take && avs_write_i && avs_address_i == cftu_pkg::ADDR_IRQ_STAT) begin
			st_next.irq_stat = st_reg.irq_stat & ~avs_writedata_i[1:0];
		end
		st_next.irq_stat = st_next.irq_stat | irq_ev;
		if (bus_take && avs_write_i && avs_address_i == cftu_pkg::ADDR_IRQ_MASK) begin
			st_next.irq_mask = avs_writedata_i[1:0];
		end
		if (bus_take && avs_write_i && avs_address_i == cftu_pkg::ADDR_COND_SEL) begin
			st_next.cond_sel = avs_writedata_i[4:0];
		end
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= '0;
			st_reg.flags <= cftu_pkg::FLAG_RST; // RQ13 RQ14
			st_reg.wait_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cpu_flag_word_o = st_reg.flags;
	assign result_o = st_reg.result;
	assign result_valid_o = st_reg.res_valid;
	assign avs_readdata_o = st_reg.rdata;
	assign avs_waitrequest_o = st_reg.wait_n;
	assign irq_o = st_reg.irq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_always_true_code: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ1
		(cond_i == cftu_pkg::CC_ALWAYS) |-> cond_pass_o)
		else $error("Always-true condition did not pass");

	a_addr_reg_no_flags: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ3
		(res_valid_i && !cmp_op_i && !dst_ext_i && !fw_write) |=> $stable(cpu_flag_word_o))
		else $error("Flags moved on a non-extended destination");

	a_compare_updates: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ4
		(res_valid_i && cmp_op_i && !fw_write && op_class_i == cftu_pkg::CLS_LOGIC)
		|=> cpu_flag_word_o[cftu_pkg::FB_ZERO] == ($past(word_res_i) == 32'h0000_0000))
		else $error("Compare did not update the zero flag");

	a_logic_v_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ9
		(upd && !fw_write && op_class_i == cftu_pkg::CLS_LOGIC) |=> !cpu_flag_word_o[cftu_pkg::FB_OVF])
		else $error("Logical op left overflow set");

	a_add_carry_out: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
		(upd && !fw_write && op_class_i == cftu_pkg::CLS_INT && int_op_i == cftu_pkg::IOP_ADD)
		|=> cpu_flag_word_o[cftu_pkg::FB_CARRY] == (result_o[31:0] < $past(op_a_i)))
		else $error("Add carry flag wrong");

	a_carry_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ11
		(upd && !fw_write && op_class_i != cftu_pkg::CLS_INT)
		|=> cpu_flag_word_o[cftu_pkg::FB_CARRY] == $past(cpu_flag_word_o[cftu_pkg::FB_CARRY]))
		else $error("Carry changed on float or logical op");

	a_uf_forces_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ12
		(upd && op_class_i == cftu_pkg::CLS_FLOAT && flt_uf)
		|=> cpu_flag_word_o[cftu_pkg::FB_UF] && result_o[31:0] == 32'h0000_0000 && result_valid_o)
		else $error("Underflow did not zero the output");

	a_lv_follows_v: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ13
		(upd && hw_flags[cftu_pkg::FB_OVF]) |=> cpu_flag_word_o[cftu_pkg::FB_LV])
		else $error("Sticky overflow missed an overflow");

	a_luf_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ14
		(cpu_flag_word_o[cftu_pkg::FB_LUF] && !fw_write) |=> cpu_flag_word_o[cftu_pkg::FB_LUF])
		else $error("Sticky underflow dropped without a write");

	a_bus_one_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("Bus answer took more than one wait cycle");

	// Condition checks read the flag word port, not the decode function,
	// so a slip in the case table shows up here
	a_equal_test: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ17
		(cond_i == cftu_pkg::CC_SAME_VALUE) |-> cond_pass_o == cpu_flag_word_o[cftu_pkg::FB_ZERO])
		else $error("Equal condition disagrees with zero flag");

	a_unsigned_above: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ15
		(cond_i == cftu_pkg::CC_UNSIGNED_ABOVE)
		|-> cond_pass_o == (!cpu_flag_word_o[cftu_pkg::FB_CARRY] && !cpu_flag_word_o[cftu_pkg::FB_ZERO]))
		else $error("Unsigned above condition wrong");

	a_signed_at_most: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ16
		(cond_i == cftu_pkg::CC_SIGNED_AT_MOST)
		|-> cond_pass_o == (cpu_flag_word_o[cftu_pkg::FB_SIGN] || cpu_flag_word_o[cftu_pkg::FB_ZERO]))
		else $error("Signed at-most condition wrong");

	a_ovf_test: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ18
		(cond_i == cftu_pkg::CC_OVF) |-> cond_pass_o == cpu_flag_word_o[cftu_pkg::FB_OVF])
		else $error("Overflow condition wrong");

	// Flag checks look one cycle on; the sign and zero checks compare against the registered result
	a_logic_sign_msb: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ6
		(upd && !fw_write && op_class_i == cftu_pkg::CLS_LOGIC) |=> cpu_flag_word_o[cftu_pkg::FB_SIGN] == result_o[31])
		else $error("Logical sign flag is not the output msb");

	a_zero_matches: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ7
		(upd && !fw_write && op_class_i != cftu_pkg::CLS_FLOAT)
		|=> cpu_flag_word_o[cftu_pkg::FB_ZERO] == (result_o[31:0] == 32'h0000_0000))
		else $error("Zero flag disagrees with the output");

	a_float_ovf: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ9
		(upd && !fw_write && op_class_i == cftu_pkg::CLS_FLOAT && !flt_zero_i
		&& $signed(flt_exp_i) > cftu_pkg::FLT_EXP_MAX) |=> cpu_flag_word_o[cftu_pkg::FB_OVF])
		else $error("Float overflow not flagged");

	a_uf_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ12
		(upd && !fw_write && !flt_uf) |=> !cpu_flag_word_o[cftu_pkg::FB_UF])
		else $error("Underflow flag left set without an underflow");

	a_sub_borrow: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
		(upd && !fw_write && op_class_i == cftu_pkg::CLS_INT && int_op_i == cftu_pkg::IOP_SUB)
		|=> cpu_flag_word_o[cftu_pkg::FB_CARRY] == ($past(op_a_i) < $past(op_b_i)))
		else $error("Subtract borrow flag wrong");

	a_other_int_c: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
		(upd && !fw_write && op_class_i == cftu_pkg::CLS_INT && int_op_i[1])
		|=> !cpu_flag_word_o[cftu_pkg::FB_CARRY])
		else $error("Carry not cleared on other integer op");

	a_luf_follows_uf: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ14
		(upd && hw_flags[cftu_pkg::FB_UF]) |=> cpu_flag_word_o[cftu_pkg::FB_LUF])
		else $error("Sticky underflow missed an underflow");

	a_ovf_event_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(upd && hw_flags[cftu_pkg::FB_OVF]) |=> st_reg.irq_stat[cftu_pkg::IB_OVF])
		else $error("Overflow event not recorded");

	a_valid_follows: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		res_valid_i |=> result_valid_o)
		else $error("Result valid did not follow the datapath");

endmodule : cftu_flag_unit
`default_nettype wire

// ---- cftu_dp_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Execution datapath stand-in
// ----------------------------------------
module cftu_dp_model (
	input wire logic clk_i,
	output logic res_valid_o,
	output logic [1:0] op_class_o,
	output logic [1:0] int_op_o,
	output logic cmp_op_o,
	output logic dst_ext_o,
	output logic [31:0] op_a_o,
	output logic [31:0] op_b_o,
	output logic [31:0] word_res_o,
	output logic int_ovf_o,
	output logic [9:0] flt_exp_o,
	output logic flt_sign_o,
	output logic [30:0] flt_frac_o,
	output logic flt_zero_o
);
	// Quiet datapath at time zero
	initial begin
		{res_valid_o, op_class_o, int_op_o, cmp_op_o, dst_ext_o, int_ovf_o} = 8'h00;
		{op_a_o, op_b_o, word_res_o} = 96'h0;
		{flt_exp_o, flt_sign_o, flt_frac_o, flt_zero_o} = 43'h0;
	end

	// One result for one cycle; md is {compare, extended destination}
	task issue(input logic [1:0] c, input logic [1:0] k, input logic [1:0] md,
		input logic [31:0] a, input logic [31:0] b, input logic [9:0] e, input logic z);
		@(posedge clk_i);
		res_valid_o <= 1'b1;
		op_class_o <= c;
		int_op_o <= k;
		{cmp_op_o, dst_ext_o} <= md;
		op_a_o <= a;
		op_b_o <= b;
		word_res_o <= a; // Logical and other-integer output shares the a word
		int_ovf_o <= e[0]; // Other-integer overflow rides on e[0]
		flt_exp_o <= e;
		{flt_sign_o, flt_frac_o} <= a;
		flt_zero_o <= z;
		@(posedge clk_i);
		res_valid_o <= 1'b0;
		// Stale qualifiers scramble so a late read never sees the old result
		{op_a_o, op_b_o, word_res_o} <= ~{op_a_o, op_b_o, word_res_o};
		{cmp_op_o, dst_ext_o, int_ovf_o, flt_zero_o} <= ~{cmp_op_o, dst_ext_o, int_ovf_o, flt_zero_o};
		flt_exp_o <= ~flt_exp_o;
	endtask : issue
endmodule : cftu_dp_model
`default_nettype wire

// ---- cftu_flag_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cftu_flag_unit_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [4:0] cond = 5'h00;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdat = 32'h0;
	logic rv, cmp, dst, iov, fs, fz, pass, vld, wait_r, irq;
	logic [1:0] cls, iop;
	logic [31:0] oa, ob, wres, rdat, q;
	logic [9:0] fe;
	logic [30:0] ff;
	logic [6:0] flags;
	logic [39:0] res;
	int n_fail = 0;
	int tests_run = 0;

	always #2.5 clk = ~clk;

	cftu_dp_model i_cftu_dp_model (.clk_i(clk), .res_valid_o(rv), .op_class_o(cls), .int_op_o(iop),
		.cmp_op_o(cmp), .dst_ext_o(dst), .op_a_o(oa), .op_b_o(ob), .word_res_o(wres), .int_ovf_o(iov),
		.flt_exp_o(fe), .flt_sign_o(fs), .flt_frac_o(ff), .flt_zero_o(fz));

	cftu_flag_unit i_cftu_flag_unit (.clk_i(clk), .rst_b_i(rst_b), .res_valid_i(rv), .op_class_i(cls),
		.int_op_i(iop), .cmp_op_i(cmp), .dst_ext_i(dst), .op_a_i(oa), .op_b_i(ob), .word_res_i(wres),
		.int_ovf_i(iov), .flt_exp_i(fe), .flt_sign_i(fs), .flt_frac_i(ff), .flt_zero_i(fz),
		.cond_i(cond), .cond_pass_o(pass), .cpu_flag_word_o(flags), .result_o(res),
		.result_valid_o(vld), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r), .irq_o(irq));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [39:0] s, input logic [39:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// Request stands until waitrequest is sampled low; a stuck slave counts as a miss
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdat <= d;
		@(posedge clk);
		for (k = 0; k < 20 && wait_r !== 1'b0; k++)
			@(posedge clk);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k == 20) n_fail++;
	endtask : bus

	// Flags are looked at once the answering edge has landed
	task op(input logic [1:0] c, input logic [1:0] k, input logic [1:0] md,
		input logic [31:0] a, input logic [31:0] b, input logic [9:0] e);
		i_cftu_dp_model.issue(c, k, md, a, b, e, 1'b0);
		#1;
	endtask : op

	// Reference condition table, bits {luf, lv, uf, n, z, v, c}
	function automatic logic exp_cond(input logic [4:0] c, input logic [6:0] f);
		logic cy, v, z, n, u, lv, lu;
		{lu, lv, u, n, z, v, cy} = f;
		case (c)
			5'h00: return 1'b1;
			5'h01: return cy;
			5'h02: return cy | z;
			5'h03: return ~cy & ~z;
			5'h04: return ~cy;
			5'h05: return z;
			5'h06: return ~z;
			5'h07: return n;
			5'h08: return n | z;
			5'h09: return ~n & ~z;
			5'h0a: return ~n;
			5'h0b: return ~v;
			5'h0c: return v;
			5'h0d: return ~u;
			5'h0e: return u;
			5'h0f: return ~lv;
			5'h10: return lv;
			5'h11: return ~lu;
			5'h12: return lu;
			5'h13: return z | u;
			default: return 1'b0;
		endcase
	endfunction : exp_cond

	task close_out;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Register reset values; 0x10 is a hole that must read zero and ignore writes
	task t_reset;
		chk(40'(flags), 40'h0);
		chk(res, 40'h0);
		chk(40'(vld), 40'h0);
		chk(40'(wait_r), 40'h1);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 5'(i * 4), 32'h0);
			chk(40'(q), (i == 3) ? 40'h100 : 40'h0);
		end
		bus(1'b1, 5'h10, 32'h7f);
		bus(1'b0, 5'h00, 32'h0);
		chk(40'(q), 40'h0);
	endtask : t_reset

	// Integer edges: signed wrap, carry out, borrow, then an ignored destination
	task t_int;
		op(2'h1, 2'h0, 2'h1, 32'h7fffffff, 32'h1, 10'h0);
		chk(40'(vld), 40'h1);
		chk(res, 40'h0080000000);
		chk(40'(flags), 40'h2a);
		op(2'h1, 2'h0, 2'h1, 32'hffffffff, 32'h1, 10'h0);
		chk(40'(flags), 40'h25);
		op(2'h1, 2'h1, 2'h1, 32'h0, 32'h1, 10'h0);
		chk(40'(flags), 40'h29);
		op(2'h1, 2'h1, 2'h1, 32'h80000000, 32'h1, 10'h0);
		chk(40'(flags), 40'h22);
		op(2'h1, 2'h2, 2'h1, 32'h0, 32'h0, 10'h1);
		chk(40'(flags), 40'h26);
		op(2'h1, 2'h0, 2'h0, 32'h1, 32'h1, 10'h0);
		chk(res, 40'h2);
		chk(40'(flags), 40'h26);
	endtask : t_int

	// Logical results keep carry; a compare to a plain register still updates
	task t_logic;
		op(2'h0, 2'h0, 2'h1, 32'h80000000, 32'h0, 10'h0);
		chk(40'(flags), 40'h28);
		op(2'h1, 2'h1, 2'h2, 32'h1, 32'h2, 10'h0);
		chk(40'(flags), 40'h29);
		op(2'h0, 2'h0, 2'h1, 32'h0, 32'h0, 10'h0);
		chk(40'(flags), 40'h25);
		op(2'h0, 2'h0, 2'h2, 32'h10, 32'h0, 10'h0);
		chk(40'(flags), 40'h21);
	endtask : t_logic

	// Exponent boundaries 128/127 and -128/-127
	task t_float;
		op(2'h2, 2'h0, 2'h1, 32'h0, 32'h0, 10'h080);
		chk(40'(flags), 40'h23);
		op(2'h2, 2'h0, 2'h1, 32'h80000000, 32'h0, 10'h07f);
		chk(40'(flags), 40'h29);
		chk(res, 40'h7f80000000);
		op(2'h2, 2'h0, 2'h1, 32'h80000001, 32'h0, 10'h380);
		chk(40'(flags), 40'h75);
		chk(res, 40'h8000000000);
		op(2'h2, 2'h0, 2'h1, 32'h0, 32'h0, 10'h381);
		chk(40'(flags), 40'h61);
		chk(res, 40'h8100000000);
	endtask : t_float

	// Both events pending; unmask overflow, then clear the overflow bit alone
	task t_irq;
		bus(1'b0, 5'h04, 32'h0);
		chk(40'(q), 40'h3);
		chk(40'(irq), 40'h0);
		bus(1'b1, 5'h08, 32'h1);
		@(posedge clk);
		#1;
		chk(40'(irq), 40'h1);
		bus(1'b1, 5'h04, 32'h1);
		@(posedge clk);
		#1;
		chk(40'(irq), 40'h0);
		bus(1'b0, 5'h04, 32'h0);
		chk(40'(q), 40'h2);
	endtask : t_irq

	// Every code over several flag words loaded through the bus
	task t_cond;
		logic [6:0] pat [5] = '{7'h7f, 7'h00, 7'h0d, 7'h32, 7'h05};
		foreach (pat[i]) begin
			bus(1'b1, 5'h00, 32'(pat[i]));
			bus(1'b0, 5'h00, 32'h0);
			chk(40'(q), 40'(pat[i]));
			for (int c = 0; c < 32; c++) begin
				@(posedge clk);
				cond <= 5'(c);
				#1;
				chk(40'(pass), 40'(exp_cond(5'(c), pat[i])));
			end
		end
		bus(1'b1, 5'h0c, 32'h5);
		bus(1'b0, 5'h0c, 32'h0);
		chk(40'(q), 40'h105);
	endtask : t_cond

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_int();
		t_logic();
		t_float();
		t_irq();
		t_cond();
		close_out();
	end

	// Whole run needs under 1000 cycles; a hang is cut well after that
	initial begin
		#20000;
		n_fail++;
		close_out();
	end
endmodule : cftu_flag_unit_tb_top
`default_nettype wire
